/* File: design/ctla_pkg.sv */
package ctla_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NS    = 4;       // Upstream slots (masters attach)
  localparam int SW    = 2;       // Upstream slot index width
  localparam int NM    = 2;       // downstream_slot_side slots
  localparam int DW    = 1;       // Downstream slot index width
  localparam int thread_tag_width = 2;
  localparam int TW    = thread_tag_width;
  localparam int IDW   = SW + TW; // Full transaction tag width
  localparam int CW    = 3;       // Counter width
  localparam int PRW   = 4;       // Priority field width
  localparam int PAW   = 12;      // APB address width
  // Threads per slot: smaller of acceptance and tag space
  localparam int NT    = (4 < (1 << TW)) ? 4 : (1 << TW);

  // ----------------------------------------
  // Limits and slot configuration
  // ----------------------------------------
  localparam logic [1:0][CW-1:0] ACC_LIM  = '{3'h4, 3'h4}; // rd, wr
  localparam logic [1:0][CW-1:0] ISS_LIM  = '{3'h4, 3'h4}; // rd, wr
  localparam logic [CW-1:0]      LITE_LIM = 3'h1;
  localparam logic [CW-1:0]      ONE      = 3'h1;
  localparam logic [NS-1:0]      SLOT_LITE = 4'h8;
  localparam logic [NM-1:0]      DOWN_LITE = 2'h0;
  localparam logic [NS-1:0]      SINGLE    = 4'h4;
  localparam logic [NS-1:0]      slot_fed_by_cascade = 4'h2;
  localparam logic [NS-1:0][NM-1:0] CONN = '{2'h3, 2'h3, 2'h1, 2'h3};
  localparam logic [NS-1:0][IDW-1:0] slot_base_tag =
    '{4'hc, 4'h8, 4'h4, 4'h0};
  localparam logic [IDW-1:0]     TAG_MASK = 4'h3;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam logic [PAW-1:0] A_CTRL  = 12'h000;
  localparam logic [PAW-1:0] A_PRIO  = 12'h004;
  localparam logic [PAW-1:0] A_WSTAT = 12'h008;
  localparam logic [PAW-1:0] A_RSTAT = 12'h00c;
  localparam int             MODE_BIT = 0;
  localparam logic           MODE_RST = 1'h1;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic          vld;  // Address request pending
    logic [DW-1:0] dst;  // Decoded downstream slot
    logic [TW-1:0] tag;  // Thread tag
  } ctla_req_t;

  typedef struct packed {
    logic           hs;   // Valid and ready both high
    logic           last; // Last read beat
    logic [DW-1:0]  src;  // Responding downstream slot
    logic [IDW-1:0] id;   // Full tag
  } ctla_rsp_t;

  typedef struct packed {
    logic           vld;
    logic [SW-1:0]  slot;
    logic [DW-1:0]  dst;
    logic [IDW-1:0] id;
  } ctla_iss_t;

  typedef struct packed {
    logic          vld;
    logic [SW-1:0] slot;
  } ctla_route_t;

  typedef struct packed {
    logic                               mode;
    logic [NS-1:0][PRW-1:0]             prio;
    logic [1:0][SW-1:0]                 rr;
    logic [1:0][NS-1:0][CW-1:0]         acc;
    logic [1:0][NM-1:0][CW-1:0]         iss;
    logic [1:0][NS-1:0][NT-1:0][CW-1:0] tcnt;
    logic [1:0][NS-1:0][NT-1:0][DW-1:0] tdst;
    ctla_iss_t [1:0]                    iss_o;
    ctla_route_t [1:0]                  rte;
    logic [31:0]                        prdata;
  } ctla_st_t;

  localparam ctla_st_t ST_RST = '{mode: MODE_RST, default: '0};
endpackage : ctla_pkg

/* File: design/ctla_xbar.sv */
`timescale 1ns/1ns
// Functional notes
// - Cap accepted writes and reads per slot
// - Per-thread counters, min(acceptance, tag space)
// - Cap issued writes and reads per target
// - Write response handshake decrements counters
// - Read completes only on last beat
// - Limited requests leave arbitration, others proceed
// - Lite slots allow one outstanding only
// - Highest static priority 0..15 wins
// - All priority zero: round robin
// - Priority tie above zero: lowest slot
// - Exclude slots risking deadlock
// - Shared mode: one outstanding overall
// - Sparse mode: only mapped pathways exist
// - Single-threaded slot: one tag at once
// - Multi-thread slot: one target per thread
// - Cascade-fed slot: upstream restricts threads
// - Count at the crossbar only
// - Full tag is base OR thread tag
module ctla_xbar (
  input  wire  logic                          pclk,
  input  wire  logic                          presetn,
  input  wire  logic [ctla_pkg::PAW-1:0]      paddr,
  input  wire  logic                          psel,
  input  wire  logic                          penable,
  input  wire  logic                          pwrite,
  input  wire  logic [31:0]                   pwdata,
  output logic [31:0]                         prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire  ctla_pkg::ctla_req_t [1:0][ctla_pkg::NS-1:0] req,
  output logic [1:0][ctla_pkg::NS-1:0]        req_rdy,
  input  wire  ctla_pkg::ctla_rsp_t [1:0]     rsp,
  output ctla_pkg::ctla_iss_t [1:0]           issue,
  output ctla_pkg::ctla_route_t [1:0]         route
);
  localparam int NS   = ctla_pkg::NS;
  localparam int TOTW = ctla_pkg::CW + 3;

  // ----------------------------------------
  // State
  // ----------------------------------------
  ctla_pkg::ctla_st_t             st_q;  // Registered state
  ctla_pkg::ctla_st_t             st_d;  // Next state
  logic [1:0][NS-1:0]             gnt;   // Grants per channel
  logic [1:0][NS-1:0]             qual;  // Qualified requests
  logic [TOTW-1:0]                tot;   // All accepted outstanding
  logic                           blk;   // Shared mode grant taken
  logic                           ok;    // Qualification scratch
  logic [ctla_pkg::DW-1:0]        d;     // Request target
  logic [ctla_pkg::TW-1:0]        t;     // Request tag
  logic [ctla_pkg::CW-1:0]        lim;   // Acceptance limit
  logic [ctla_pkg::CW-1:0]        ilim;  // Issuing limit
  logic                           any;   // Some slot qualified
  logic                           fnd;   // Round robin hit
  logic [ctla_pkg::PRW-1:0]       maxp;  // Best priority seen
  logic [ctla_pkg::SW-1:0]        win;   // Winning slot
  logic [ctla_pkg::SW-1:0]        idx;   // Round robin probe
  logic [ctla_pkg::SW-1:0]        rs;    // Response slot
  logic [ctla_pkg::TW-1:0]        rt;    // Response tag
  logic                           unmap; // Unmapped APB address

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    gnt  = '0;
    qual = '0;
    tot  = '0;
    blk  = 1'b0;
    ok   = 1'b0;
    d    = '0;
    t    = '0;
    lim  = '0;
    ilim = '0;
    any  = 1'b0;
    fnd  = 1'b0;
    maxp = '0;
    win  = '0;
    idx  = '0;
    rs   = '0;
    rt   = '0;
    // Outstanding total over both channels
    for (int c = 0; c < 2; c++) begin
      st_d.iss_o[c].vld = 1'b0;
      st_d.rte[c].vld   = 1'b0;
      for (int s = 0; s < NS; s++) begin
        tot = tot + TOTW'(st_q.acc[c][s]);
      end
    end
    for (int c = 0; c < 2; c++) begin
      // Qualify each slot
      for (int s = 0; s < NS; s++) begin
        d = req[c][s].dst;
        t = req[c][s].tag;
        lim  = ctla_pkg::SLOT_LITE[s] ? ctla_pkg::LITE_LIM
                                      : ctla_pkg::ACC_LIM[c];
        ilim = ctla_pkg::DOWN_LITE[d] ? ctla_pkg::LITE_LIM
                                      : ctla_pkg::ISS_LIM[c];
        ok = req[c][s].vld && ctla_pkg::CONN[s][d];
        ok = ok && (st_q.acc[c][s] < lim) && (st_q.iss[c][d] < ilim);
        if (ctla_pkg::SINGLE[s]) begin
          ok = ok && ((st_q.acc[c][s] == '0) ||
                      (st_q.tcnt[c][s][t] != '0));
        end else if (!ctla_pkg::slot_fed_by_cascade[s]) begin
          ok = ok && ((st_q.tcnt[c][s][t] == '0) ||
                      (st_q.tdst[c][s][t] == d));
        end
        if (!st_q.mode) begin
          ok = ok && (tot == '0) && !blk;
        end
        qual[c][s] = ok;
      end
      any  = 1'b0;
      maxp = '0;
      win  = '0;
      for (int s = 0; s < NS; s++) begin
        if (qual[c][s] && (!any || st_q.prio[s] > maxp)) begin
          any  = 1'b1;
          maxp = st_q.prio[s];
          win  = ctla_pkg::SW'(s);
        end
      end
      if (any && maxp == '0) begin
        fnd = 1'b0;
        for (int k = 1; k <= NS; k++) begin
          idx = ctla_pkg::SW'(st_q.rr[c] + ctla_pkg::SW'(k));
          if (!fnd && qual[c][idx]) begin
            fnd = 1'b1;
            win = idx;
          end
        end
      end
      // Grant and count
      if (any) begin
        d = req[c][win].dst;
        t = req[c][win].tag;
        gnt[c][win] = 1'b1;
        blk = 1'b1;
        st_d.rr[c] = win;
        st_d.acc[c][win] = st_d.acc[c][win] + ctla_pkg::ONE;
        st_d.iss[c][d]   = st_d.iss[c][d] + ctla_pkg::ONE;
        st_d.tcnt[c][win][t] = st_d.tcnt[c][win][t] + ctla_pkg::ONE;
        st_d.tdst[c][win][t] = d;
        st_d.iss_o[c].vld  = 1'b1;
        st_d.iss_o[c].slot = win;
        st_d.iss_o[c].dst  = d;
        st_d.iss_o[c].id = ctla_pkg::slot_base_tag[win] |
                           {{ctla_pkg::SW{1'b0}}, t};
      end
      if (rsp[c].hs && (c == 0 || rsp[c].last)) begin
        for (int s = 0; s < NS; s++) begin
          if ((rsp[c].id & ~ctla_pkg::TAG_MASK) ==
              ctla_pkg::slot_base_tag[s]) begin
            rs = ctla_pkg::SW'(s);
          end
        end
        rt = rsp[c].id[ctla_pkg::TW-1:0];
        if (st_q.acc[c][rs] != '0) begin
          st_d.acc[c][rs] = st_d.acc[c][rs] - ctla_pkg::ONE;
        end
        if (st_q.iss[c][rsp[c].src] != '0) begin
          st_d.iss[c][rsp[c].src] = st_d.iss[c][rsp[c].src] -
                                    ctla_pkg::ONE;
        end
        if (st_q.tcnt[c][rs][rt] != '0) begin
          st_d.tcnt[c][rs][rt] = st_d.tcnt[c][rs][rt] - ctla_pkg::ONE;
        end
        st_d.rte[c].vld  = 1'b1;
        st_d.rte[c].slot = rs;
      end
    end
    // APB read data captured in setup phase
    if (psel && !penable) begin
      case (paddr)
        ctla_pkg::A_CTRL:  st_d.prdata = 32'(st_q.mode);
        ctla_pkg::A_PRIO:  st_d.prdata = 32'(st_q.prio);
        ctla_pkg::A_WSTAT: st_d.prdata = 32'(st_q.acc[0]);
        ctla_pkg::A_RSTAT: st_d.prdata = 32'(st_q.acc[1]);
        default:           st_d.prdata = '0;
      endcase
    end
    // APB writes in access phase
    if (psel && penable && pwrite) begin
      case (paddr)
        ctla_pkg::A_CTRL: st_d.mode = pwdata[ctla_pkg::MODE_BIT];
        ctla_pkg::A_PRIO: st_d.prio = pwdata[$bits(st_q.prio)-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ctla_pkg::ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign unmap   = !(paddr inside {ctla_pkg::A_CTRL, ctla_pkg::A_PRIO,
                                   ctla_pkg::A_WSTAT, ctla_pkg::A_RSTAT});
  assign pready  = 1'b1;
  assign pslverr = psel && penable && unmap;
  assign prdata  = st_q.prdata;
  assign req_rdy = gnt;
  assign issue   = st_q.iss_o;
  assign route   = st_q.rte;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic acc_over;  // Some slot past its limit
  logic prio_bad;  // Winner outranked by a qualified slot
  logic [ctla_pkg::SW-1:0] bslot;  // Slot of write response
  logic [ctla_pkg::CW-1:0] bacc;   // Its acceptance count
  logic [ctla_pkg::SW-1:0] wslot;  // Slot granted on write channel

  // Helper flags
  always_comb begin
    acc_over = 1'b0;
    prio_bad = 1'b0;
    wslot    = '0;
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < NS; s++) begin
        // Write grant slot, kept apart from the read winner
        if (c == 0 && gnt[c][s]) begin
          wslot = ctla_pkg::SW'(s);
        end
        if (st_q.acc[c][s] > ctla_pkg::ACC_LIM[c] ||
            (ctla_pkg::SLOT_LITE[s] &&
             st_q.acc[c][s] > ctla_pkg::LITE_LIM)) begin
          acc_over = 1'b1;
        end
        for (int o = 0; o < NS; o++) begin
          if (gnt[c][s] && qual[c][o] &&
              st_q.prio[o] > st_q.prio[s]) begin
            prio_bad = 1'b1;
          end
        end
      end
    end
  end
  assign bslot = rsp[0].id[ctla_pkg::IDW-1:ctla_pkg::TW];
  assign bacc  = st_q.acc[0][bslot];

  a_acc_cap: assert property (!acc_over)
    else $error("acceptance count over limit");
  a_wiss_cap: assert property (
    st_q.iss[0][0] <= ctla_pkg::ISS_LIM[0] &&
    st_q.iss[0][1] <= ctla_pkg::ISS_LIM[0] &&
    st_q.iss[1][0] <= ctla_pkg::ISS_LIM[1] &&
    st_q.iss[1][1] <= ctla_pkg::ISS_LIM[1])
    else $error("issuing count over limit");
  a_grant_qual: assert property (
    (gnt[0] & ~qual[0]) == '0 && (gnt[1] & ~qual[1]) == '0)
    else $error("grant to unqualified slot");
  a_grant_one: assert property (
    $onehot0(gnt[0]) && $onehot0(gnt[1]))
    else $error("more than one grant");
  a_prio_win: assert property (!prio_bad)
    else $error("lower priority slot granted");
  a_b_dec: assert property (
    rsp[0].hs && gnt[0] == '0 && bacc != '0
    |=> st_q.acc[0][$past(bslot)] == $past(bacc) - ctla_pkg::ONE)
    else $error("write response did not decrement");
  a_r_keep: assert property (
    rsp[1].hs && !rsp[1].last && gnt[1] == '0 |=> $stable(st_q.acc[1]))
    else $error("read counted done before last beat");
  a_shared_one: assert property (
    !st_q.mode && tot != '0 |-> gnt == '0)
    else $error("second transaction in shared mode");
  a_grant_issue: assert property (
    gnt[0] != '0 |=> issue[0].vld && issue[0].slot == $past(wslot))
    else $error("grant not followed by issue");
  a_id_form: assert property (
    issue[1].vld |-> issue[1].id[ctla_pkg::IDW-1:ctla_pkg::TW]
                     == issue[1].slot)
    else $error("issued tag lacks slot base");

  c_rr_grant: cover property (gnt[0] != '0 && st_q.prio == '0);
  c_limited: cover property (req[0][0].vld && !qual[0][0]);
  c_b_done: cover property (rsp[0].hs && bacc != '0);
  c_shared: cover property (!st_q.mode && gnt[1] != '0);
endmodule : ctla_xbar

/* File: tb/ctla_far_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Far side: answers issued transfers in order
// ----------------------------------------
module ctla_far_model (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      stall,
  input  wire ctla_pkg::ctla_iss_t [1:0] issue,
  output ctla_pkg::ctla_rsp_t [1:0]      rsp
);
  ctla_pkg::ctla_iss_t q[2][$]; // Pending transfers, oldest first

  // Queue issues, answer after a random wait
  always @(posedge pclk or negedge presetn) begin
    logic lst; // Beat closes the transfer
    if (!presetn) begin
      q[0].delete();
      q[1].delete();
      rsp <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (issue[c].vld) begin
          q[c].push_back(issue[c]);
        end
        if (q[c].size() > 0 && !stall && $urandom % 3 != 0) begin
          // Reads may send extra beats first
          lst = (c == 0) || ($urandom % 2 == 1);
          rsp[c] <= '{1'b1, lst, q[c][0].dst, q[c][0].id};
          if (lst) begin
            void'(q[c].pop_front());
          end
        end else begin
          // Idle fields toggle so stale values never pass
          rsp[c] <= {1'b0, ~rsp[c][5:0]};
        end
      end
    end
  end
endmodule : ctla_far_model

/* File: tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                       pclk, presetn, psel, penable, pwrite;
  logic [11:0]                paddr;
  logic [31:0]                pwdata, prdata, erd;
  logic                       pready, pslverr, eerr, stall, run;
  logic [1:0][3:0]            req_rdy;
  ctla_pkg::ctla_req_t [1:0][3:0] req;
  ctla_pkg::ctla_rsp_t [1:0]  rsp;
  ctla_pkg::ctla_iss_t [1:0]  issue, eis;
  ctla_pkg::ctla_route_t [1:0] route, ert;
  int acc[2][4], iss[2][2], tc[2][4][4], td[2][4][4]; // Model counts
  int pr[4], rr[2], md, ph, n_fail, samples_checked;

  ctla_xbar i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
    .req_rdy(req_rdy), .rsp(rsp), .issue(issue), .route(route));
  ctla_far_model i_far (.pclk(pclk), .presetn(presetn), .stall(stall),
    .issue(issue), .rsp(rsp));

  // Clock, 4 ns
  always begin
    #2;
    pclk = ~pclk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // Register bus transfer, read data checked against model
  task automatic apb(logic [11:0] a, logic w, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk("pslverr", 32'(pslverr), 32'(eerr));
    if (!w) chk("prdata", prdata, erd);
    psel <= 0;
    penable <= 0;
  endtask : apb

  // Model register view
  function automatic logic [31:0] rexp(logic [11:0] a);
    rexp = '0;
    case (a)
      ctla_pkg::A_CTRL: rexp[0] = md[0];
      ctla_pkg::A_PRIO: for (int s = 0; s < 4; s++) rexp[4*s+:4] = 4'(pr[s]);
      ctla_pkg::A_WSTAT, ctla_pkg::A_RSTAT:
        for (int s = 0; s < 4; s++) rexp[3*s+:3] = 3'(acc[a[2]][s]);
      default: rexp = '0;
    endcase
  endfunction : rexp

  // Whether a pending request may enter arbitration
  function automatic bit ok(int c, int s);
    ctla_pkg::ctla_req_t r;
    r = req[c][s];
    ok = r.vld === 1'b1 && ctla_pkg::CONN[s][r.dst] && acc[c][s] <
      (ctla_pkg::SLOT_LITE[s] ? 1 : int'(ctla_pkg::ACC_LIM[c]));
    ok = ok && iss[c][r.dst] < int'(ctla_pkg::ISS_LIM[c]);
    for (int t = 0; t < 4; t++)
      if (ctla_pkg::SINGLE[s] && t != r.tag && tc[c][s][t] > 0) ok = 0;
    if (!ctla_pkg::SINGLE[s] && !ctla_pkg::slot_fed_by_cascade[s] &&
        tc[c][s][r.tag] > 0 && td[c][s][r.tag] != r.dst) ok = 0;
    if (md == 0 && acc[0].sum() + acc[1].sum() > 0) ok = 0;
  endfunction : ok

  // Winner of one channel, -1 for none
  function automatic int arb(int c);
    int mx;
    mx = -1;
    arb = -1;
    for (int s = 0; s < 4; s++)
      if (ok(c, s) && pr[s] > mx) begin
        mx = pr[s];
        arb = s;
      end
    if (mx == 0)
      for (int k = 4; k >= 1; k--)
        if (ok(c, (rr[c] + k) % 4)) arb = (rr[c] + k) % 4;
  endfunction : arb

  // ----------------------------------------
  // Model, checks and traffic at each edge
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    int w[2], s, t;
    ctla_pkg::ctla_req_t r;
    if (!presetn) begin
      acc = '{default: 0};
      iss = '{default: 0};
      tc = '{default: 0};
      td = '{default: 0};
      pr = '{default: 0};
      rr = '{default: 0};
      md = int'(ctla_pkg::MODE_RST);
      eis = '0;
      ert = '0;
      req <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        chk("issue", issue[c].vld ? 32'(issue[c]) : '0,
          32'(eis[c]));
        chk("route", route[c].vld ? 32'(route[c]) : '0,
          32'(ert[c]));
        w[c] = arb(c);
      end
      // Shared mode: write wins the cycle
      if (md == 0 && w[0] >= 0) w[1] = -1;
      for (int c = 0; c < 2; c++)
        chk("req_rdy", 32'(req_rdy[c]),
          w[c] < 0 ? 0 : 32'(1) << w[c]);
      if (psel && !penable) begin
        erd <= rexp(paddr);
        eerr <= !(paddr inside {[12'h000:12'h00c]}) || paddr[1:0] != 0;
      end
      for (int c = 0; c < 2; c++) begin
        eis[c] = '0;
        ert[c] = '0;
        if (rsp[c].hs && (c == 0 || rsp[c].last)) begin
          s = int'(rsp[c].id[3:2]);
          t = int'(rsp[c].id[1:0]);
          ert[c] = '{1'b1, 2'(s)};
          if (acc[c][s] > 0) acc[c][s]--;
          if (iss[c][rsp[c].src] > 0) iss[c][rsp[c].src]--;
          if (tc[c][s][t] > 0) tc[c][s][t]--;
        end
        if (w[c] >= 0) begin
          r = req[c][w[c]];
          acc[c][w[c]]++;
          iss[c][r.dst]++;
          tc[c][w[c]][r.tag]++;
          td[c][w[c]][r.tag] = r.dst;
          rr[c] = w[c];
          eis[c] = '{1'b1, 2'(w[c]), r.dst,
            ctla_pkg::slot_base_tag[w[c]] | 4'(r.tag)};
        end
        // New or held requests
        for (int k = 0; k < 4; k++)
          if (run && (!req[c][k].vld || w[c] == k)) req[c][k] <= '{
            1'($urandom % 4 == 0), (k == 1 && ph != 2) ? 1'b0 : 1'($urandom),
            2'($urandom)};
      end
      if (psel && penable && pwrite && pready) begin
        if (paddr == ctla_pkg::A_CTRL) md = int'(pwdata[ctla_pkg::MODE_BIT]);
        if (paddr == ctla_pkg::A_PRIO)
          for (int k = 0; k < 4; k++) pr[k] = int'(pwdata[4*k+:4]);
      end
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    wrap_up();
  end

  // ----------------------------------------
  // Phases: mixed, stalled far side, all zero priority, shared mode
  // ----------------------------------------
  initial begin
    int seed;
    {pclk, presetn, psel, penable, pwrite, stall, run} = '0;
    paddr = '0;
    pwdata = '0;
    ph = 0;
    n_fail = 0;
    samples_checked = 0;
    seed = $urandom(58);
    for (int p = 0; p < 4; p++) begin
      ph <= p;
      run <= 0;
      presetn <= 0;
      repeat (3) @(posedge pclk);
      presetn <= 1;
      // Reset values, unmapped place, read-only status
      for (int i = 0; i < 5; i++) apb(12'(4 * i), 0, '0);
      apb(ctla_pkg::A_WSTAT, 1, '1);
      apb(ctla_pkg::A_CTRL, 1, p == 3 ? '0 : 32'h1);
      apb(ctla_pkg::A_PRIO, 1, p == 2 ? '0 : $urandom);
      stall <= (p == 1);
      run <= 1;
      repeat (100) @(posedge pclk);
      stall <= 0;
      for (int i = 0; i < 40; i++) apb(12'(4 * ($urandom % 5)), 0, '0);
    end
    wrap_up();
  end
endmodule : testbench
